// [include/map_cfg_pkg.sv]
package map_cfg_pkg;
  localparam int ADDR_W = 16;
  localparam int LADDR_W = 32;
  localparam int SLOT_COUNT = 16;
  localparam int N_UNITS = 8;
  localparam int UNIT_W = 4;
  localparam int UNIT_IDX_W = 3;
  localparam int CFG_BYTES = 11;
  localparam int CFG_W = 8 * CFG_BYTES;
  localparam logic [7:0] MAP_PAGE = 8'h06;
  localparam logic [15:0] MAP_BASE = 16'h0600;
  localparam logic [15:0] MAP_LAST = 16'h06FF;
  localparam logic [3:0] OFS_LSTART = 4'h0;
  localparam logic [3:0] OFS_LEN = 4'h4;
  localparam logic [3:0] OFS_LBIT = 4'h6;
  localparam logic [3:0] OFS_SBIT = 4'h7;
  localparam logic [3:0] OFS_PSTART = 4'h8;
  localparam logic [3:0] OFS_PBIT = 4'hA;
  localparam logic [3:0] OFS_TYPE = 4'hB;
  localparam logic [3:0] OFS_ACT = 4'hC;
  localparam int POS_LSTART = 0;
  localparam int POS_LEN = 32;
  localparam int POS_LBIT = 48;
  localparam int POS_SBIT = 56;
  localparam int POS_PSTART = 64;
  localparam int POS_PBIT = 80;
  localparam int TYPE_RD_BIT = 0;
  localparam int TYPE_WR_BIT = 1;
  localparam logic [1:0] TYPE_RESET = 2'h0;
  localparam logic ACT_RESET = 1'b0;
  localparam logic [7:0] BIT_FIELD_MASK = 8'h07;
  localparam logic [7:0] TYPE_FIELD_MASK = 8'h03;
  localparam logic [7:0] ACT_FIELD_MASK = 8'h01;
  typedef enum logic [2:0] {
    SCAN_IDLE = 3'b001,
    SCAN_FETCH = 3'b010,
    SCAN_CHECK = 3'b100
  } scan_state_type;
endpackage

// [logic/map_cfg_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module map_cfg_mem (
  input wire logic ref_clk_i,
  input wire logic we_i,
  input wire logic [map_cfg_pkg::UNIT_IDX_W-1:0] w_unit_i,
  input wire logic [3:0] w_byte_i,
  input wire logic [7:0] w_data_i,
  input wire logic [map_cfg_pkg::UNIT_IDX_W-1:0] a_unit_i,
  output logic [map_cfg_pkg::CFG_W-1:0] a_word_o,
  input wire logic [map_cfg_pkg::UNIT_IDX_W-1:0] b_unit_i,
  output logic [map_cfg_pkg::CFG_W-1:0] b_word_o
);
  import map_cfg_pkg::*;

  logic [CFG_W-1:0] mem [0:N_UNITS-1];

  always_ff @(posedge ref_clk_i) begin
    if (we_i && (w_byte_i < 4'(CFG_BYTES))) begin
      mem[w_unit_i][8*w_byte_i +: 8] <= w_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    a_word_o <= mem[a_unit_i];
  end

  always_ff @(posedge ref_clk_i) begin
    b_word_o <= mem[b_unit_i];
  end
endmodule
`default_nettype wire

// [logic/logical_mapping_unit_set.sv]
`timescale 1ns/1ps
`default_nettype none
// Operation
// R01 - Sixteen 16-byte unit slots at 0x0600-0x06FF
// R02 - Only N_UNITS slots implemented, rest read zero
// R03 - 32-bit logical start address at +0..3
// R04 - 16-bit byte length at +4..5
// R05 - Logical first bit at +6, LSB is 0
// R06 - Logical last bit at +7
// R07 - Physical start address at +8..9 maps start
// R08 - Physical first bit at +0xA receives start bit
// R09 - Type bits enable read and write mapping
// R10 - Only active units check and map accesses
// R11 - Fieldbus writes config, host port reads only
// R12 - Covered bits redirected to physical address/bit
module logical_mapping_unit_set (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic fb_req_i,
  input wire logic fb_we_i,
  input wire logic [map_cfg_pkg::ADDR_W-1:0] fb_addr_i,
  input wire logic [7:0] fb_wdata_i,
  output logic fb_ack_o,
  output logic [7:0] fb_rdata_o,
  input wire logic hp_req_i,
  input wire logic hp_we_i,
  input wire logic [map_cfg_pkg::ADDR_W-1:0] hp_addr_i,
  input wire logic [7:0] hp_wdata_i,
  output logic hp_ack_o,
  output logic [7:0] hp_rdata_o,
  input wire logic map_req_i,
  input wire logic map_write_i,
  input wire logic [map_cfg_pkg::LADDR_W-1:0] map_laddr_i,
  output logic map_busy_o,
  output logic map_done_o,
  output logic map_hit_o,
  output logic [map_cfg_pkg::UNIT_W-1:0] map_unit_o,
  output logic [15:0] map_paddr_o,
  output logic [2:0] map_pbit_o,
  output logic [7:0] map_mask_o
);
  import map_cfg_pkg::*;

  // Address lies in an implemented unit slot
  function automatic logic unit_addr_ok(input logic [ADDR_W-1:0] a);
    unit_addr_ok = (a[15:8] == MAP_PAGE) && (a[7:4] < 4'(N_UNITS)); // [R01] [R02]
  endfunction

  // Reserved bits of the narrow fields always store zero
  function automatic logic [7:0] field_mask(input logic [3:0] ofs);
    unique case (ofs)
      OFS_LBIT, OFS_SBIT, OFS_PBIT: field_mask = BIT_FIELD_MASK;
      OFS_TYPE: field_mask = TYPE_FIELD_MASK;
      OFS_ACT: field_mask = ACT_FIELD_MASK;
      default: field_mask = 8'hFF;
    endcase
  endfunction

  logic fb_busy_reg;
  logic hp_busy_reg;
  logic fb_take;
  logic hp_take;
  logic [ADDR_W-1:0] acc_addr;
  logic acc_is_fb_reg;
  logic acc_valid_reg;
  logic acc_ok_reg;
  logic [3:0] acc_byte_reg;
  logic [UNIT_IDX_W-1:0] acc_unit_reg;
  logic [7:0] rd_byte;
  logic cfg_we;
  logic [CFG_W-1:0] a_word;
  logic [CFG_W-1:0] b_word;
  logic [1:0] type_reg [0:N_UNITS-1];
  logic act_reg [0:N_UNITS-1];
  scan_state_type state_reg;
  logic [UNIT_IDX_W-1:0] scan_unit_reg;

  assign fb_take = fb_req_i && !fb_busy_reg;
  assign hp_take = hp_req_i && !hp_busy_reg && !fb_take;
  assign acc_addr = fb_take ? fb_addr_i : hp_addr_i;
  // Host writes never reach the configuration
  assign cfg_we = fb_take && fb_we_i && unit_addr_ok(fb_addr_i); // [R11]

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      fb_busy_reg <= 1'b0;
    end else if (fb_take) begin
      fb_busy_reg <= 1'b1;
    end else if (fb_ack_o) begin
      fb_busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      hp_busy_reg <= 1'b0;
    end else if (hp_take) begin
      hp_busy_reg <= 1'b1;
    end else if (hp_ack_o) begin
      hp_busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      acc_valid_reg <= 1'b0;
      acc_is_fb_reg <= 1'b0;
      acc_ok_reg <= 1'b0;
      acc_byte_reg <= 4'h0;
      acc_unit_reg <= '0;
    end else begin
      acc_valid_reg <= fb_take || hp_take;
      acc_is_fb_reg <= fb_take;
      acc_ok_reg <= unit_addr_ok(acc_addr);
      acc_byte_reg <= acc_addr[3:0];
      acc_unit_reg <= acc_addr[UNIT_IDX_W+3:4];
    end
  end

  // Type and activate are control state and reset to disabled
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      for (int u = 0; u < N_UNITS; u++) begin
        type_reg[u] <= TYPE_RESET;
        act_reg[u] <= ACT_RESET;
      end
    end else if (cfg_we) begin
      if (fb_addr_i[3:0] == OFS_TYPE) begin
        type_reg[fb_addr_i[UNIT_IDX_W+3:4]] <= fb_wdata_i[1:0]; // [R09]
      end
      if (fb_addr_i[3:0] == OFS_ACT) begin
        act_reg[fb_addr_i[UNIT_IDX_W+3:4]] <= fb_wdata_i[0]; // [R10]
      end
    end
  end

  map_cfg_mem u_mem (
    .ref_clk_i(ref_clk_i),
    .we_i(cfg_we),
    .w_unit_i(fb_addr_i[UNIT_IDX_W+3:4]),
    .w_byte_i(fb_addr_i[3:0]),
    .w_data_i(fb_wdata_i & field_mask(fb_addr_i[3:0])), // [R03] [R04] [R05] [R06] [R07] [R08]
    .a_unit_i(acc_addr[UNIT_IDX_W+3:4]),
    .a_word_o(a_word),
    .b_unit_i(scan_unit_reg),
    .b_word_o(b_word)
  );

  // Byte view of one slot; unimplemented and reserved bytes read zero
  always_comb begin
    rd_byte = 8'h00;
    if (acc_ok_reg) begin
      if (acc_byte_reg < 4'(CFG_BYTES)) begin
        rd_byte = a_word[8*acc_byte_reg +: 8]; // [R02]
      end else if (acc_byte_reg == OFS_TYPE) begin
        rd_byte = {6'h00, type_reg[acc_unit_reg]};
      end else if (acc_byte_reg == OFS_ACT) begin
        rd_byte = {7'h00, act_reg[acc_unit_reg]};
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      fb_ack_o <= 1'b0;
      hp_ack_o <= 1'b0;
      fb_rdata_o <= 8'h00;
      hp_rdata_o <= 8'h00;
    end else begin
      fb_ack_o <= acc_valid_reg && acc_is_fb_reg;
      hp_ack_o <= acc_valid_reg && !acc_is_fb_reg; // [R11]
      if (acc_valid_reg && acc_is_fb_reg) begin
        fb_rdata_o <= rd_byte;
      end
      if (acc_valid_reg && !acc_is_fb_reg) begin
        hp_rdata_o <= rd_byte;
      end
    end
  end

  // Lookup of one logical byte, one unit every two cycles
  logic [LADDR_W-1:0] laddr_reg;
  logic write_reg;
  logic [LADDR_W-1:0] lstart;
  logic [15:0] blen;
  logic [2:0] lbit;
  logic [2:0] sbit;
  logic [15:0] pstart;
  logic [2:0] pbit;
  logic [LADDR_W:0] diff;
  logic dir_en;
  logic in_win;
  logic [2:0] lo_bit;
  logic [2:0] hi_bit;
  logic [7:0] cov_mask;
  logic [19:0] phys_bits;
  logic hit;

  assign lstart = b_word[POS_LSTART +: 32];
  assign blen = b_word[POS_LEN +: 16];
  assign lbit = b_word[POS_LBIT +: 3];
  assign sbit = b_word[POS_SBIT +: 3];
  assign pstart = b_word[POS_PSTART +: 16];
  assign pbit = b_word[POS_PBIT +: 3];

  always_comb begin
    diff = {1'b0, laddr_reg} - {1'b0, lstart};
    dir_en = write_reg ? type_reg[scan_unit_reg][TYPE_WR_BIT]
                       : type_reg[scan_unit_reg][TYPE_RD_BIT]; // [R09]
    in_win = !diff[LADDR_W] && (diff[LADDR_W-1:0] < {16'h0000, blen}); // [R03] [R04]
    lo_bit = (diff[LADDR_W-1:0] == '0) ? lbit : 3'h0; // [R05]
    hi_bit = (diff[LADDR_W-1:0] == {16'h0000, blen - 16'h0001}) ? sbit : 3'h7; // [R06]
    for (int i = 0; i < 8; i++) begin
      cov_mask[i] = (3'(i) >= lo_bit) && (3'(i) <= hi_bit);
    end
    hit = act_reg[scan_unit_reg] && dir_en && in_win && (cov_mask != 8'h00); // [R10]
    // Bit distance from the window start, moved onto the physical start bit
    phys_bits = {1'b0, diff[15:0], 3'h0} + {17'h00000, lo_bit}
              - {17'h00000, lbit} + {17'h00000, pbit}; // [R08] [R12]
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_reg <= SCAN_IDLE;
      scan_unit_reg <= '0;
      laddr_reg <= '0;
      write_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        SCAN_IDLE: begin
          if (map_req_i) begin
            state_reg <= SCAN_FETCH;
            scan_unit_reg <= '0;
            laddr_reg <= map_laddr_i;
            write_reg <= map_write_i;
          end
        end
        SCAN_FETCH: begin
          state_reg <= SCAN_CHECK;
        end
        SCAN_CHECK: begin
          if (hit || (scan_unit_reg == UNIT_IDX_W'(N_UNITS - 1))) begin
            state_reg <= SCAN_IDLE;
          end else begin
            state_reg <= SCAN_FETCH;
            scan_unit_reg <= scan_unit_reg + 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      map_done_o <= 1'b0;
      map_hit_o <= 1'b0;
      map_unit_o <= '0;
      map_paddr_o <= 16'h0000;
      map_pbit_o <= 3'h0;
      map_mask_o <= 8'h00;
    end else begin
      map_done_o <= (state_reg == SCAN_CHECK)
                    && (hit || (scan_unit_reg == UNIT_IDX_W'(N_UNITS - 1)));
      if (state_reg == SCAN_CHECK && hit) begin
        map_hit_o <= 1'b1;
        map_unit_o <= UNIT_W'(scan_unit_reg);
        map_paddr_o <= pstart + phys_bits[18:3]; // [R07] [R12]
        map_pbit_o <= phys_bits[2:0]; // [R12]
        map_mask_o <= cov_mask;
      end else if (state_reg == SCAN_IDLE && map_req_i) begin
        map_hit_o <= 1'b0;
        map_mask_o <= 8'h00;
      end
    end
  end

  assign map_busy_o = (state_reg != SCAN_IDLE);
endmodule
`default_nettype wire

// [bench/map_set_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module map_set_chk (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic fb_req_i,
  input wire logic fb_ack_o,
  input wire logic [7:0] fb_rdata_o,
  input wire logic hp_req_i,
  input wire logic hp_ack_o,
  input wire logic map_req_i,
  input wire logic map_busy_o,
  input wire logic map_done_o,
  input wire logic map_hit_o,
  input wire logic [map_cfg_pkg::UNIT_W-1:0] map_unit_o,
  input wire logic [15:0] map_paddr_o,
  input wire logic [7:0] map_mask_o
);
  import map_cfg_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  fb_ack_lat_a: assert property (fb_ack_o |-> $past(fb_req_i, 2) && !$past(fb_ack_o))
    else $error("fb ack out of turn");
  hp_ack_lat_a: assert property (hp_ack_o |-> $past(hp_req_i, 2) && !$past(hp_ack_o))
    else $error("hp ack out of turn");
  rdata_hold_a: assert property (!fb_ack_o |-> $stable(fb_rdata_o))
    else $error("fb rdata moved without ack");
  map_start_a: assert property (map_req_i && !map_busy_o && !map_done_o |=>
    map_busy_o && !map_hit_o && map_mask_o == 8'h00) else $error("lookup not taken");
  map_bound_a: assert property ($rose(map_busy_o) |-> ##[1:17] map_done_o)
    else $error("lookup too long");
  done_pulse_a: assert property (map_done_o |-> $past(map_busy_o) ##1 !map_done_o)
    else $error("done not a pulse");
  hit_mask_a: assert property (map_hit_o |-> map_mask_o != 8'h00 && map_unit_o < N_UNITS)
    else $error("hit with bad mask or unit");
  result_hold_a: assert property (!map_busy_o && !map_done_o && !$past(map_busy_o) |->
    $stable(map_paddr_o) && $stable(map_mask_o) && $stable(map_hit_o))
    else $error("lookup result moved");
endmodule
`default_nettype wire

// [bench/reg_port_master.sv]
`timescale 1ns/1ps
`default_nettype none
module reg_port_master (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [7:0] rdata_i,
  output logic req_o,
  output logic we_o,
  output logic [15:0] addr_o,
  output logic [7:0] wdata_o
);
  initial begin
    req_o = 1'b0;
    we_o = 1'b0;
    addr_o = 16'h0000;
    wdata_o = 8'h00;
  end
  // Released lines are scrambled so stale values cannot pass
  task automatic xfer(input logic we, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    #1 req_o = 1'b1;
    we_o = we;
    addr_o = a;
    wdata_o = d;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while (ack_i !== 1'b1 && n < 20);
    q = rdata_i;
    // Request stands through the edge that samples the ack
    @(posedge clk_i);
    #1 req_o = 1'b0;
    we_o = ~we;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import map_cfg_pkg::*;
  logic ref_clk_i, srst_i, fb_req, fb_we, fb_ack, hp_req, hp_we, hp_ack;
  logic map_req, map_write, map_busy, map_done, map_hit;
  logic [15:0] fb_addr, hp_addr, map_paddr;
  logic [7:0] fb_wdata, fb_rdata, hp_wdata, hp_rdata, map_mask, q;
  logic [31:0] map_laddr, rng;
  logic [3:0] map_unit;
  logic [2:0] map_pbit;
  logic [7:0] cfg [16][16];
  int n_fail, total_checks, cyc;
  logical_mapping_unit_set logical_mapping_unit_set_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .fb_req_i(fb_req), .fb_we_i(fb_we), .fb_addr_i(fb_addr), .fb_wdata_i(fb_wdata),
    .fb_ack_o(fb_ack), .fb_rdata_o(fb_rdata), .hp_req_i(hp_req), .hp_we_i(hp_we),
    .hp_addr_i(hp_addr), .hp_wdata_i(hp_wdata), .hp_ack_o(hp_ack), .hp_rdata_o(hp_rdata),
    .map_req_i(map_req), .map_write_i(map_write), .map_laddr_i(map_laddr),
    .map_busy_o(map_busy), .map_done_o(map_done), .map_hit_o(map_hit), .map_unit_o(map_unit),
    .map_paddr_o(map_paddr), .map_pbit_o(map_pbit), .map_mask_o(map_mask));
  reg_port_master fbm_i (.clk_i(ref_clk_i), .ack_i(fb_ack), .rdata_i(fb_rdata), .req_o(fb_req),
    .we_o(fb_we), .addr_o(fb_addr), .wdata_o(fb_wdata));
  reg_port_master hpm_i (.clk_i(ref_clk_i), .ack_i(hp_ack), .rdata_i(hp_rdata), .req_o(hp_req),
    .we_o(hp_we), .addr_o(hp_addr), .wdata_o(hp_wdata));
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  function automatic logic [7:0] fmask(int u, int o);
    if (u >= N_UNITS || o > 12) return 8'h00;
    if (o == 6 || o == 7 || o == 10) return 8'h07;
    if (o == 11) return 8'h03;
    return (o == 12) ? 8'h01 : 8'hFF;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d failures=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic lookup(input logic w, input logic [31:0] la);
    logic [31:0] d;
    logic [7:0] mm;
    logic [7:0] m = 8'h00;
    logic [15:0] ea = 16'h0000;
    logic [3:0] eu = 4'h0;
    logic [2:0] eb = 3'h0;
    int n, lo, off;
    // Descending scan so the lowest matching unit wins
    for (int u = N_UNITS - 1; u >= 0; u--) begin
      d = la - {cfg[u][3], cfg[u][2], cfg[u][1], cfg[u][0]};
      mm = 8'hFF;
      if (d == 0) mm = mm & (8'hFF << cfg[u][6]);
      if (d == {cfg[u][5], cfg[u][4]} - 1) mm = mm & (8'hFF >> (7 - cfg[u][7]));
      if (cfg[u][12][0] && cfg[u][11][w] && d < {cfg[u][5], cfg[u][4]} && mm != 8'h00) begin
        lo = 0;
        while (!mm[lo]) lo++;
        off = d * 8 + lo - cfg[u][6] + cfg[u][10];
        m = mm;
        eu = 4'(u);
        ea = {cfg[u][9], cfg[u][8]} + 16'(off >> 3);
        eb = 3'(off);
      end
    end
    @(posedge ref_clk_i);
    #1 map_req = 1'b1;
    map_write = w;
    map_laddr = la;
    @(posedge ref_clk_i);
    #1 map_req = 1'b0;
    map_laddr = ~la;
    n = 0;
    while (map_done !== 1'b1 && n < 20) begin
      @(posedge ref_clk_i);
      #1 n++;
    end
    check(map_done, 1'b1);
    check({map_hit, map_mask}, {m != 8'h00, m});
    if (m != 8'h00) check({map_unit, map_paddr, map_pbit}, {eu, ea, eb});
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc > 12000) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    logic [7:0] v;
    int a;
    rng = 32'h0000001B;
    srst_i = 1'b1;
    map_req = 1'b0;
    map_write = 1'b0;
    map_laddr = 32'h00000000;
    foreach (cfg[i, j]) cfg[i][j] = 8'h00;
    repeat (8) @(posedge ref_clk_i);
    #1 srst_i = 1'b0;
    check({map_busy, map_hit, map_mask}, 32'h0);
    for (a = 0; a < 16; a++) begin
      fbm_i.xfer(1'b0, MAP_BASE + 16'(a * 16 + 11 + a % 2), 8'h00, q);
      check(q, 8'h00);
    end
    lookup(1'b1, rnd());
    for (a = 0; a < 256; a++) begin
      v = 8'(rnd());
      if (a % 16 == 4) v = v & 8'h03;
      if (a % 16 == 5) v = 8'h00;
      fbm_i.xfer(1'b1, MAP_BASE + 16'(a), v, q);
      cfg[a / 16][a % 16] = v & fmask(a / 16, a % 16);
    end
    for (a = 0; a < 256; a++) begin
      hpm_i.xfer(1'b1, MAP_BASE + 16'(a), ~cfg[a / 16][a % 16], q);
      fbm_i.xfer(1'b0, MAP_BASE + 16'(a), 8'h00, q);
      check(q, cfg[a / 16][a % 16]);
      hpm_i.xfer(1'b0, MAP_BASE + 16'(a), 8'h00, q);
      check(q, cfg[a / 16][a % 16]);
    end
    repeat (100) begin
      a = int'(rnd() % 8);
      v = 8'(rnd());
      lookup(v[7], {cfg[a][3], cfg[a][2], cfg[a][1], cfg[a][0]} + 32'(v[1:0]) - 32'h1);
    end
    wrap_up();
  end
endmodule
bind logical_mapping_unit_set map_set_chk map_set_chk_i (.ref_clk_i(ref_clk_i),
  .srst_i(srst_i), .fb_req_i(fb_req_i), .fb_ack_o(fb_ack_o), .fb_rdata_o(fb_rdata_o),
  .hp_req_i(hp_req_i), .hp_ack_o(hp_ack_o), .map_req_i(map_req_i), .map_busy_o(map_busy_o),
  .map_done_o(map_done_o), .map_hit_o(map_hit_o), .map_unit_o(map_unit_o),
  .map_paddr_o(map_paddr_o), .map_mask_o(map_mask_o));
`default_nettype wire
